// ==== rtl/lss_top.sv ====
// LED sink shift-latch chain with AHB-Lite registers and a word FIFO
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps

// ****************************************************************
// Word FIFO
// ****************************************************************
module lss_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    // Pointers carry a spare bit so that full and empty differ
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic push;
    logic pop;

    assign level = wr_ptr_ff - rd_ptr_ff;
    assign in_ready = (level != DEPTH[AW:0]);
    assign out_valid = (wr_ptr_ff != rd_ptr_ff);
    // Head word is shown without a read cycle of latency
    assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_ptr_ff <= '0;
        end else if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rd_ptr_ff <= '0;
        end else if (pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end
endmodule

// Notes on behaviour
// RQ1: 32 stages, each shift flop plus latch
// RQ2: Shift only on rising shift clock edge; in software mode the chain shifts FIFO words and ignores the pin
// RQ3: Serial in enters stage 1, stages advance
// RQ4: Latch transparent while hold low, captures high
// RQ5: Hold high freezes outputs, shifting continues
// RQ6: Cascade output always shows stage 32
// RQ7: Longer chains: cascade feeds next data input
// RQ8: Set low forces all stages, latches one
// RQ9: Outputs open-drain inverted, sink on one
// RQ10: Disable high floats all sinks, cascade drives
// RQ11: Disable never touches chain or shifting
// RQ12: Set acts without clock, overrides shifting
module lss_top #(
    parameter int CHAIN = lss_pkg::CHAIN_LEN,
    parameter int DEPTH = lss_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic serial_in,
    input wire logic shift_clk,
    input wire logic latch_hold_n,
    input wire logic set_n,
    input wire logic out_disable,
    output logic [CHAIN-1:0] led_sink_outputs,
    output logic [CHAIN-1:0] led_sink_oe_n,
    output logic cascade_out,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp
);
    // Offsets compare against the word-aligned low address byte
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    logic [CHAIN-1:0] chain_ff;
    logic [CHAIN-1:0] nxt_chain;
    logic [CHAIN-1:0] latch_ff;
    logic [CHAIN-1:0] nxt_latch;
    logic [CHAIN-1:0] oe_n_ff;
    logic [CHAIN-1:0] sink_ff;
    logic shift_clk_prev_ff;
    logic pin_shift;
    logic sw_mode_ff;
    lss_pkg::lss_shift_e sh_state_ff;
    logic [31:0] sw_word_ff;
    logic [4:0] sw_cnt_ff;
    logic sw_shift;
    logic pend_ff;
    logic pend_write_ff;
    logic [7:0] pend_addr_ff;
    logic hreadyout_ff;
    logic [31:0] hrdata_ff;
    logic hresp_ff;
    logic addr_phase;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [31:0] fifo_out_data;
    logic [$clog2(DEPTH):0] fifo_level;
    logic [31:0] rd_value;
    logic data_stall;

    // ************************************************************
    // Shift chain
    // ************************************************************
    // Pins are synchronous to clk, so the edge is found by comparison
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shift_clk_prev_ff <= 1'b0;
        end else begin
            shift_clk_prev_ff <= shift_clk;
        end
    end

    assign pin_shift = shift_clk & ~shift_clk_prev_ff & ~sw_mode_ff; // see RQ2
    assign sw_shift = (sh_state_ff == lss_pkg::SH_SHIFT);

    // Software shifts win, so pin edges in software mode are lost
    always_comb begin
        nxt_chain = chain_ff;
        if (sw_shift) begin
            nxt_chain = {chain_ff[CHAIN-2:0], sw_word_ff[31]};
        end else if (pin_shift) begin
            nxt_chain = {chain_ff[CHAIN-2:0], serial_in}; // see RQ3
        end
    end

    // Hold low makes the latch follow the chain in the same cycle
    always_comb begin
        nxt_latch = latch_ff; // see RQ5
        if (!latch_hold_n) begin
            nxt_latch = nxt_chain; // see RQ4
        end
    end

    // Set is an asynchronous preset to a constant; it outranks reset
    always_ff @(posedge clk or negedge set_n) begin
        if (!set_n) begin
            chain_ff <= '1; // see RQ8 see RQ12
        end else if (!reset_n) begin
            chain_ff <= lss_pkg::CHAIN_RESET[CHAIN-1:0];
        end else begin
            chain_ff <= nxt_chain; // see RQ1
        end
    end

    always_ff @(posedge clk or negedge set_n) begin
        if (!set_n) begin
            latch_ff <= '1; // see RQ8 see RQ12
        end else if (!reset_n) begin
            latch_ff <= lss_pkg::CHAIN_RESET[CHAIN-1:0];
        end else begin
            latch_ff <= nxt_latch; // see RQ1
        end
    end

    // ************************************************************
    // Sink pins
    // ************************************************************
    // Enables trail the latch by one cycle so the pins come from flops
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            oe_n_ff <= '1;
        end else begin
            oe_n_ff <= ~(latch_ff & {CHAIN{~out_disable}}); // see RQ9 see RQ10
        end
    end

    // Open-drain pins only ever pull low; the enable carries the data
    always_ff @(posedge clk) begin
        sink_ff <= '0; // see RQ9
    end

    assign led_sink_outputs = sink_ff;
    assign led_sink_oe_n = oe_n_ff;
    // Stage 32 is a flop, driven even while sinks float
    assign cascade_out = chain_ff[CHAIN-1]; // see RQ6 see RQ7 see RQ11

    // ************************************************************
    // Software shifter fed from the FIFO
    // ************************************************************
    assign fifo_out_ready = sw_mode_ff & (sh_state_ff == lss_pkg::SH_IDLE);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sh_state_ff <= lss_pkg::SH_IDLE;
        end else begin
            case (sh_state_ff)
                lss_pkg::SH_IDLE: begin
                    if (fifo_out_valid & fifo_out_ready) begin
                        sh_state_ff <= lss_pkg::SH_SHIFT;
                    end
                end
                lss_pkg::SH_SHIFT: begin
                    if (sw_cnt_ff == lss_pkg::LAST_BIT_CNT) begin
                        sh_state_ff <= lss_pkg::SH_IDLE;
                    end
                end
                default: begin
                    sh_state_ff <= lss_pkg::SH_IDLE;
                end
            endcase
        end
    end

    // Word goes out MSB first, so bit 31 ends in stage 32
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sw_word_ff <= '0;
            sw_cnt_ff <= '0;
        end else if (fifo_out_valid & fifo_out_ready) begin
            sw_word_ff <= fifo_out_data;
            sw_cnt_ff <= '0;
        end else if (sw_shift) begin
            sw_word_ff <= {sw_word_ff[30:0], 1'b0};
            sw_cnt_ff <= sw_cnt_ff + 1'b1;
        end
    end

    lss_fifo #(
        .WIDTH(lss_pkg::FIFO_WIDTH),
        .DEPTH(DEPTH)
    ) u_lss_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(hwdata),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    // ************************************************************
    // AHB-Lite slave
    // ************************************************************
    assign addr_phase = hsel & htrans[1] & hready;
    assign fifo_in_valid = pend_ff & pend_write_ff
        & hit(pend_addr_ff, lss_pkg::OFS_DATA);
    // A full FIFO holds the data phase with wait states
    assign data_stall = fifo_in_valid & ~fifo_in_ready;

    // Decode uses the address registered in the address phase
    always_comb begin
        rd_value = '0;
        case (pend_addr_ff)
            lss_pkg::OFS_CTRL:
                rd_value[lss_pkg::CTRL_SW_MODE_BIT] = sw_mode_ff;
            lss_pkg::OFS_SHIFT: rd_value = 32'(chain_ff);
            lss_pkg::OFS_LATCH: rd_value = 32'(latch_ff);
            lss_pkg::OFS_STATUS: begin
                rd_value[lss_pkg::STAT_EMPTY_BIT] = ~fifo_out_valid;
                rd_value[lss_pkg::STAT_FULL_BIT] = ~fifo_in_ready;
                rd_value[lss_pkg::STAT_BUSY_BIT] = sw_shift;
                rd_value[lss_pkg::STAT_LEVEL_LSB +: 8] = 8'(fifo_level);
            end
            default: rd_value = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pend_ff <= 1'b0;
            pend_write_ff <= 1'b0;
            pend_addr_ff <= '0;
        end else if (addr_phase) begin
            pend_ff <= 1'b1;
            pend_write_ff <= hwrite;
            pend_addr_ff <= {haddr[7:2], 2'b00};
        end else if (pend_ff & ~data_stall) begin
            pend_ff <= 1'b0;
        end
    end

    // Every transfer takes one wait state, the decode cycle; a data write to a full FIFO takes more
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hreadyout_ff <= 1'b1;
        end else if (addr_phase) begin
            hreadyout_ff <= 1'b0;
        end else if (pend_ff & ~data_stall) begin
            hreadyout_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hrdata_ff <= '0;
        end else if (pend_ff & ~pend_write_ff) begin
            hrdata_ff <= rd_value;
        end
    end

    // A word already being shifted finishes even if the mode is cleared
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sw_mode_ff <= lss_pkg::CTRL_RESET[lss_pkg::CTRL_SW_MODE_BIT];
        end else if (pend_ff & pend_write_ff
                     & hit(pend_addr_ff, lss_pkg::OFS_CTRL)) begin
            sw_mode_ff <= hwdata[lss_pkg::CTRL_SW_MODE_BIT];
        end
    end

    // No access can fail, so every response is OKAY
    always_ff @(posedge clk) begin
        hresp_ff <= 1'b0;
    end

    assign hreadyout = hreadyout_ff;
    assign hrdata = hrdata_ff;
    assign hresp = hresp_ff;
endmodule

// ==== inc/lss_pkg.sv ====
// Package with constants and types for the LED sink shift-latch block
package lss_pkg;
    // ************************************************************
    // Chain and buffer sizes
    // ************************************************************
    localparam int CHAIN_LEN = 32;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = 32;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_SHIFT = 8'h08;
    localparam logic [7:0] OFS_LATCH = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // ************************************************************
    // Field positions, reset values and the last shift count
    // ************************************************************
    localparam int CTRL_SW_MODE_BIT = 0;
    localparam int STAT_EMPTY_BIT = 0;
    localparam int STAT_FULL_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_LEVEL_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CHAIN_RESET = 32'h0000_0000;
    localparam logic [4:0] LAST_BIT_CNT = 5'h1F;

    // ************************************************************
    // Software shifter states
    // ************************************************************
    typedef enum logic [1:0] {
        SH_IDLE = 2'b01,
        SH_SHIFT = 2'b10
    } lss_shift_e;
endpackage

// ==== tb/lss_ctrl_model.sv ====
// Behavioural model of the controller that drives the pin link
`timescale 1ns/1ps
module lss_ctrl_model (
    input wire logic clk,
    output logic serial_in,
    output logic shift_clk,
    output logic latch_hold_n,
    output logic set_n,
    output logic out_disable
);
    initial begin
        serial_in = 1'b0;
        shift_clk = 1'b0;
        latch_hold_n = 1'b1;
        set_n = 1'b1;
        out_disable = 1'b0;
    end

    task automatic ctl(input logic hold_n, input logic sn, input logic od);
        @(posedge clk);
        latch_hold_n <= hold_n;
        set_n <= sn;
        out_disable <= od;
    endtask

    // Data flips once its hold is over, so a late sample shows up
    task automatic shift_bit(input logic d);
        @(posedge clk);
        serial_in <= d;
        shift_clk <= 1'b1;
        @(posedge clk);
        shift_clk <= 1'b0;
        serial_in <= ~d;
    endtask

    // First bit sent ends at the cascade end, ready for the next device
    task automatic shift_word(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            shift_bit(w[i]);
        end
    endtask
endmodule

// ==== tb/lss_checker.sv ====
// Checker on the ports of the shift-latch block
`timescale 1ns/1ps
module lss_checker #(
    parameter int CHAIN = 32
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic serial_in,
    input wire logic shift_clk,
    input wire logic latch_hold_n,
    input wire logic set_n,
    input wire logic out_disable,
    input wire logic [CHAIN-1:0] led_sink_outputs,
    input wire logic [CHAIN-1:0] led_sink_oe_n,
    input wire logic cascade_out,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp
);
    logic sclk_ff, pend_ff, sw_ff, rise;
    assign rise = shift_clk && !sclk_ff;
    // Track software mode from CTRL writes, since pin shifts are ignored while it is on
    always_ff @(posedge clk) begin
        sclk_ff <= shift_clk;
        if (!reset_n) begin
            pend_ff <= 1'b0;
            sw_ff <= 1'b0;
        end else begin
            if (pend_ff && hreadyout) begin
                sw_ff <= hwdata[0];
            end
            if (hsel && htrans[1] && hready) begin
                pend_ff <= hwrite && haddr[7:0] == lss_pkg::OFS_CTRL;
            end else if (hreadyout) begin
                pend_ff <= 1'b0;
            end
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_still;
        (!sw_ff && set_n && !rise) ##1 set_n |-> $stable(cascade_out);
    endproperty
    a_still: assert property (p_still)
        else $error("cascade moved without a shift");
    property p_pass;
        (rise && !sw_ff && set_n && !latch_hold_n) ##1 (set_n && !out_disable)
            |=> led_sink_oe_n[0] == !$past(serial_in, 2);
    endproperty
    a_pass: assert property (p_pass)
        else $error("first sink does not follow shifted bit");
    property p_hold;
        (latch_hold_n && set_n && !out_disable) ##1 (set_n && !out_disable)
            |=> $stable(led_sink_oe_n);
    endproperty
    a_hold: assert property (p_hold)
        else $error("sinks changed while held");
    property p_set_casc;
        !set_n |-> cascade_out;
    endproperty
    a_set_casc: assert property (p_set_casc)
        else $error("cascade low during set");
    property p_set_sink;
        !set_n && !out_disable |=> led_sink_oe_n == '0;
    endproperty
    a_set_sink: assert property (p_set_sink)
        else $error("sink off during set");
    property p_drain;
        led_sink_outputs == '0;
    endproperty
    a_drain: assert property (p_drain)
        else $error("sink drives high");
    property p_float;
        out_disable |=> &led_sink_oe_n;
    endproperty
    a_float: assert property (p_float)
        else $error("sink on while disabled");
    property p_rd;
        hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd: assert property (p_rd)
        else $error("read answer timing wrong");
    property p_okay;
        !hresp;
    endproperty
    a_okay: assert property (p_okay)
        else $error("response not okay");
endmodule

bind lss_top lss_checker #(.CHAIN(CHAIN)) u_lss_checker (.*);

// ==== tb/lss_top_tb.sv ====
// Self-checking bench for the LED sink shift-latch block
`timescale 1ns/1ps
module lss_top_tb;
    localparam logic [31:0] PAT = 32'hC3A5_0F96;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] rdat, hrdata, led_sink_outputs, led_sink_oe_n;
    logic hready, hreadyout, hresp, cascade_out;
    logic serial_in, shift_clk, latch_hold_n, set_n, out_disable;
    int n_mismatch = 0;
    int n_tests = 0;

    assign hready = hreadyout;
    lss_top u_lss_top (.*);
    lss_ctrl_model u_lss_ctrl_model (.*);

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic end_of_test();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // A full FIFO stretches a write, so both phases wait on hready
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        for (int p = 0; p < 2; p++) begin
            do begin
                @(posedge clk);
                n++;
            end while (hreadyout !== 1'b1 && n < 2000);
            if (p == 0) begin
                htrans <= 2'b00;
                hwdata <= wd;
            end
        end
        rdat = hrdata;
        if (n >= 2000) begin
            n_mismatch++;
            end_of_test();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        rd(lss_pkg::OFS_CTRL, lss_pkg::CTRL_RESET);
        rd(lss_pkg::OFS_STATUS, 32'h0000_0001);
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0);
        u_lss_ctrl_model.shift_word(PAT);
        rd(lss_pkg::OFS_SHIFT, PAT);
        chk({31'h0, cascade_out}, {31'h0, PAT[31]});
        rd(lss_pkg::OFS_LATCH, lss_pkg::CHAIN_RESET);
        chk(led_sink_oe_n, 32'hFFFF_FFFF);
        u_lss_ctrl_model.ctl(1'b0, 1'b1, 1'b0);
        repeat (3) @(posedge clk);
        chk(led_sink_oe_n, ~PAT);
        u_lss_ctrl_model.shift_bit(1'b0);
        repeat (3) @(posedge clk);
        chk(led_sink_oe_n, ~{PAT[30:0], 1'b0});
        chk({31'h0, cascade_out}, {31'h0, PAT[30]});
        u_lss_ctrl_model.ctl(1'b0, 1'b1, 1'b1);
        u_lss_ctrl_model.shift_bit(1'b1);
        repeat (3) @(posedge clk);
        chk(led_sink_oe_n, 32'hFFFF_FFFF);
        chk({31'h0, cascade_out}, {31'h0, PAT[29]});
        rd(lss_pkg::OFS_SHIFT, {PAT[29:0], 2'b01});
        u_lss_ctrl_model.ctl(1'b0, 1'b1, 1'b0);
        repeat (3) @(posedge clk);
        chk(led_sink_oe_n, ~{PAT[29:0], 2'b01});
        u_lss_ctrl_model.ctl(1'b1, 1'b0, 1'b0);
        #1;
        chk({31'h0, cascade_out}, 32'h1);
        u_lss_ctrl_model.shift_bit(1'b0);
        repeat (3) @(posedge clk);
        chk(led_sink_oe_n, 32'h0);
        chk(led_sink_outputs, 32'h0);
        rd(lss_pkg::OFS_SHIFT, 32'hFFFF_FFFF);
        rd(lss_pkg::OFS_LATCH, 32'hFFFF_FFFF);
        u_lss_ctrl_model.ctl(1'b1, 1'b1, 1'b0);
        bus(1'b1, lss_pkg::OFS_CTRL, 32'h0000_0001);
        rd(lss_pkg::OFS_CTRL, 32'h0000_0001);
        // Twenty words overrun the sixteen-word FIFO and force wait states
        for (int i = 0; i < 20; i++) begin
            bus(1'b1, lss_pkg::OFS_DATA, 32'h5A00_0000 | 32'(i));
        end
        // Stale data from the last register read must not end the poll
        rdat = 32'h0;
        for (int i = 0; i < 400 && rdat !== 32'h1; i++) begin
            bus(1'b0, lss_pkg::OFS_STATUS, 32'h0);
        end
        chk(rdat, 32'h0000_0001);
        if (rdat !== 32'h0000_0001) begin
            end_of_test();
        end
        rd(lss_pkg::OFS_SHIFT, 32'h5A00_0013);
        rd(lss_pkg::OFS_LATCH, 32'hFFFF_FFFF);
        bus(1'b1, lss_pkg::OFS_CTRL, 32'h0);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(lss_pkg::OFS_SHIFT, lss_pkg::CHAIN_RESET);
        rd(lss_pkg::OFS_CTRL, lss_pkg::CTRL_RESET);
        end_of_test();
    end
endmodule
